// >>> hw/csp_params.svh
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// Linear file window: files 10..59, register = (file - 10) * 100 + offset
`define CSP_FILE_LIN_MIN  8'h0A
`define CSP_FILE_LIN_MAX  8'h3B
`define CSP_FILE_STRIDE   16'h0064
// Register numbers reachable: 1..4964; offset limit 4964
`define CSP_REG_MIN       16'h0001
`define CSP_REG_MAX       16'h1364
// Bulk assembly file 60, arrays of 32 entries, offset 0..31
`define CSP_FILE_BULK     8'h3C
`define CSP_BULK_ENTRIES  16'h0020
`define CSP_BULK_OFS_MAX  16'h001F

`endif

// >>> hw/csp_pkg.sv
package csp_pkg;

    typedef logic [7:0]  csp_file_t;
    typedef logic [12:0] csp_ofs_t;
    typedef logic [12:0] csp_reg_t;
    typedef logic [15:0] csp_word_t;

    typedef enum logic [2:0] {
        CSP_DV_IDLE    = 3'b000,
        CSP_DV_CHECK   = 3'b001,
        CSP_DV_RDISSUE = 3'b010,
        CSP_DV_RDCAPT  = 3'b011,
        CSP_DV_WRWAIT  = 3'b100,
        CSP_DV_RESP    = 3'b101
    } csp_dev_state_e;

    typedef enum logic [1:0] {
        CSP_HS_IDLE = 2'b00,
        CSP_HS_REQ  = 2'b01,
        CSP_HS_XFER = 2'b10
    } csp_host_state_e;

endpackage

// >>> hw/csp_link_if.sv
`timescale 1ns/1ps
interface csp_link_if;
    import csp_pkg::*;

    logic      reqValid;
    logic      reqReady;
    logic      reqWrite;
    csp_file_t reqFile;
    csp_ofs_t  reqOffset;
    csp_ofs_t  reqCount;
    logic      wrValid;
    logic      wrReady;
    csp_word_t wrData;
    logic      rdValid;
    csp_word_t rdData;
    logic      rspValid;
    logic      rspErr;

    modport dev (
        input  reqValid, reqWrite, reqFile, reqOffset, reqCount, wrValid, wrData,
        output reqReady, wrReady, rdValid, rdData, rspValid, rspErr
    );

    modport host (
        output reqValid, reqWrite, reqFile, reqOffset, reqCount, wrValid, wrData,
        input  reqReady, wrReady, rdValid, rdData, rspValid, rspErr
    );
endinterface

// >>> hw/csp_mapper_dev.sv
// Contract
// [R1] Files 10-59: register = (file-10)*100 + offset
// [R2] Only files 10-59, registers 1-4964, offset<=4964
// [R3] Typed read serves reads, typed write serves writes
// [R4] File 60 reads follow produced array order
// [R5] File 60 writes go via consumed array
// [R6] File 60 offset 0-31, at most 32-offset elements
// [R7] Connection timeout or socket error raises timeout event
// [R8] Client gives start address plus element count
// [R9] Client writes only on change, reads freely
// [R10] Client avoids writing registers also cyclically written
// [R11] Out-of-range requests get error, no register touched
`timescale 1ns/1ps
`include "csp_params.svh"

module csp_mapper_dev (
    input  wire logic              clk,
    input  wire logic              rst_n,
    csp_link_if.dev                link,
    input  wire logic              connTimeout,
    input  wire logic              sockError,
    input  wire logic              cfgWe,
    input  wire logic              cfgConsumed,
    input  wire logic [4:0]        cfgIdx,
    input  wire csp_pkg::csp_reg_t cfgReg,
    output logic                   regRe,
    output logic                   regWe,
    output csp_pkg::csp_reg_t      regAddr,
    output csp_pkg::csp_word_t     regWdata,
    input  wire csp_pkg::csp_word_t regRdata,
    output logic                   timeoutEvent
);
    import csp_pkg::*;

    csp_dev_state_e state_r;
    csp_file_t      file_r;
    csp_ofs_t       off_r;
    csp_ofs_t       cnt_r;
    csp_ofs_t       idx_r;
    logic           isWrite_r;
    logic           err_r;
    logic           reqReady_r;
    logic           wrReady_r;
    logic           rdValid_r;
    csp_word_t      rdData_r;
    logic           rspValid_r;
    logic           rspErr_r;
    logic           regRe_r;
    logic           regWe_r;
    csp_reg_t       regAddr_r;
    csp_word_t      regWdata_r;
    logic           timeoutEvent_r;

    // Array storage kept here; only a handful of flops wide, no RAM macro needed
    csp_reg_t       prodMap [32];
    csp_reg_t       consMap [32];

    wire logic [15:0] fileW     = {8'h00, file_r};
    wire logic [15:0] offW      = {3'h0, off_r};
    wire logic [15:0] cntW      = {3'h0, cnt_r};
    wire logic        isLin     = (file_r >= `CSP_FILE_LIN_MIN) &&
                                  (file_r <= `CSP_FILE_LIN_MAX);              // [R2]
    wire logic        isBulk    = (file_r == `CSP_FILE_BULK);
    // File numbers below 10 wrap here; isLin masks that case out of linOk
    wire logic [31:0] linProd   = (fileW - 16'(`CSP_FILE_LIN_MIN)) * `CSP_FILE_STRIDE;
    wire logic [15:0] linStart  = 16'(linProd) + offW;                         // [R1]
    wire logic [15:0] linEnd    = linStart + cntW - 16'h0001;
    wire logic        linOk     = isLin && (cnt_r != 13'h0000) &&
                                  (offW <= `CSP_REG_MAX) &&
                                  (linStart >= `CSP_REG_MIN) &&
                                  (linEnd <= `CSP_REG_MAX);                    // [R2]
    wire logic        bulkOk    = isBulk && (cnt_r != 13'h0000) &&
                                  (offW <= `CSP_BULK_OFS_MAX) &&
                                  ((offW + cntW) <= `CSP_BULK_ENTRIES);       // [R6]
    wire logic        reqOk     = linOk || bulkOk;                             // [R11]
    wire logic [4:0]  bulkIdx   = 5'(off_r + idx_r);                           // [R6]
    wire csp_reg_t    bulkReg   = isWrite_r ? consMap[bulkIdx]                 // [R5]
                                            : prodMap[bulkIdx];                // [R4]
    wire csp_reg_t    linReg    = 13'(linStart + {3'h0, idx_r});               // [R1]
    wire csp_reg_t    curReg    = isBulk ? bulkReg : linReg;
    wire logic        lastElem  = (idx_r == 13'(cnt_r - 13'h0001));
    wire logic        reqTake   = link.reqValid && reqReady_r;
    wire logic        wrTake    = link.wrValid && wrReady_r;

    // Arrays are not reset: whoever owns them must load them before bulk use
    always_ff @(posedge clk) begin
        if (cfgWe && cfgConsumed) begin
            consMap[cfgIdx] <= cfgReg;
        end
        if (cfgWe && !cfgConsumed) begin
            prodMap[cfgIdx] <= cfgReg;
        end
    end

    // Registered so a short error pulse still reaches the output cleanly
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timeoutEvent_r <= 1'b0;
        end else begin
            timeoutEvent_r <= connTimeout || sockError;                        // [R7]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= CSP_DV_IDLE;
            file_r     <= 8'h00;
            off_r      <= 13'h0000;
            cnt_r      <= 13'h0000;
            idx_r      <= 13'h0000;
            isWrite_r  <= 1'b0;
            err_r      <= 1'b0;
            reqReady_r <= 1'b0;
            wrReady_r  <= 1'b0;
            rdValid_r  <= 1'b0;
            rdData_r   <= 16'h0000;
            rspValid_r <= 1'b0;
            rspErr_r   <= 1'b0;
            regRe_r    <= 1'b0;
            regWe_r    <= 1'b0;
            regAddr_r  <= 13'h0000;
            regWdata_r <= 16'h0000;
        end else begin
            regRe_r    <= 1'b0;
            regWe_r    <= 1'b0;
            rdValid_r  <= 1'b0;
            rspValid_r <= 1'b0;
            case (state_r)
                CSP_DV_IDLE: begin
                    reqReady_r <= !reqTake;
                    if (reqTake) begin
                        file_r    <= link.reqFile;                             // [R8]
                        off_r     <= link.reqOffset;
                        cnt_r     <= link.reqCount;
                        isWrite_r <= link.reqWrite;                            // [R3]
                        idx_r     <= 13'h0000;
                        state_r   <= CSP_DV_CHECK;
                    end
                end
                CSP_DV_CHECK: begin
                    // Whole request is checked before any access so a bad one leaves no trace
                    err_r <= !reqOk;                                           // [R11]
                    if (!reqOk) begin
                        state_r <= CSP_DV_RESP;                                // [R11]
                    end else if (isWrite_r) begin
                        wrReady_r <= 1'b1;
                        state_r   <= CSP_DV_WRWAIT;                            // [R3]
                    end else begin
                        state_r <= CSP_DV_RDISSUE;                             // [R3]
                    end
                end
                CSP_DV_RDISSUE: begin
                    regRe_r   <= 1'b1;
                    regAddr_r <= curReg;                                       // [R4]
                    state_r   <= CSP_DV_RDCAPT;
                end
                CSP_DV_RDCAPT: begin
                    // Register file answers one cycle after regRe, so wait out that pulse
                    if (!regRe_r) begin
                        rdValid_r <= 1'b1;
                        rdData_r  <= regRdata;
                        idx_r     <= idx_r + 13'h0001;
                        state_r   <= lastElem ? CSP_DV_RESP : CSP_DV_RDISSUE;
                    end
                end
                CSP_DV_WRWAIT: begin
                    // Ready drops for a cycle after each take: one word in flight, half rate
                    wrReady_r <= !wrTake;
                    if (wrTake) begin
                        regWe_r    <= 1'b1;
                        regAddr_r  <= curReg;                                  // [R5]
                        regWdata_r <= link.wrData;
                        idx_r      <= idx_r + 13'h0001;
                        if (lastElem) begin
                            state_r <= CSP_DV_RESP;
                        end
                    end
                end
                CSP_DV_RESP: begin
                    // Ready returns with the response, so only one request is ever open
                    wrReady_r  <= 1'b0;
                    rspValid_r <= 1'b1;
                    rspErr_r   <= err_r;                                       // [R11]
                    reqReady_r <= 1'b1;
                    state_r    <= CSP_DV_IDLE;
                end
                default: begin
                    state_r <= CSP_DV_IDLE;
                end
            endcase
        end
    end

    assign link.reqReady = reqReady_r;
    assign link.wrReady  = wrReady_r;
    assign link.rdValid  = rdValid_r;
    assign link.rdData   = rdData_r;
    assign link.rspValid = rspValid_r;
    assign link.rspErr   = rspErr_r;
    assign regRe         = regRe_r;
    assign regWe         = regWe_r;
    assign regAddr       = regAddr_r;
    assign regWdata      = regWdata_r;
    assign timeoutEvent  = timeoutEvent_r;

endmodule

// >>> hw/csp_client_host.sv
`timescale 1ns/1ps

module csp_client_host (
    input  wire logic               clk,
    input  wire logic               rst_n,
    csp_link_if.host                link,
    input  wire logic               cmdValid,
    input  wire logic               cmdWrite,
    input  wire csp_pkg::csp_file_t cmdFile,
    input  wire csp_pkg::csp_ofs_t  cmdOffset,
    input  wire csp_pkg::csp_ofs_t  cmdCount,
    output logic                    cmdReady,
    input  wire logic               usrWdValid,
    input  wire csp_pkg::csp_word_t usrWdData,
    output logic                    usrWdReady,
    output logic                    usrRdValid,
    output csp_pkg::csp_word_t      usrRdData,
    output logic                    doneValid,
    output logic                    doneErr
);
    import csp_pkg::*;

    csp_host_state_e state_r;
    logic            cmdReady_r;
    logic            reqValid_r;
    logic            reqWrite_r;
    csp_file_t       reqFile_r;
    csp_ofs_t        reqOffset_r;
    csp_ofs_t        reqCount_r;
    logic            wrValid_r;
    csp_word_t       wrData_r;
    logic            usrWdReady_r;
    logic            usrRdValid_r;
    csp_word_t       usrRdData_r;
    logic            doneValid_r;
    logic            doneErr_r;

    wire logic cmdTake = cmdValid && cmdReady_r;
    wire logic usrTake = usrWdValid && usrWdReady_r;
    wire logic wrDone  = wrValid_r && link.wrReady;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r      <= CSP_HS_IDLE;
            cmdReady_r   <= 1'b0;
            reqValid_r   <= 1'b0;
            reqWrite_r   <= 1'b0;
            reqFile_r    <= 8'h00;
            reqOffset_r  <= 13'h0000;
            reqCount_r   <= 13'h0000;
            wrValid_r    <= 1'b0;
            wrData_r     <= 16'h0000;
            usrWdReady_r <= 1'b0;
            usrRdValid_r <= 1'b0;
            usrRdData_r  <= 16'h0000;
            doneValid_r  <= 1'b0;
            doneErr_r    <= 1'b0;
        end else begin
            doneValid_r  <= 1'b0;
            usrRdValid_r <= link.rdValid;
            usrRdData_r  <= link.rdData;
            case (state_r)
                CSP_HS_IDLE: begin
                    cmdReady_r <= !cmdTake;
                    if (cmdTake) begin
                        // Start address and element count travel together  [R8]
                        reqValid_r  <= 1'b1;
                        reqWrite_r  <= cmdWrite;
                        reqFile_r   <= cmdFile;
                        reqOffset_r <= cmdOffset;
                        reqCount_r  <= cmdCount;
                        state_r     <= CSP_HS_REQ;
                    end
                end
                CSP_HS_REQ: begin
                    if (link.reqReady) begin
                        reqValid_r   <= 1'b0;
                        usrWdReady_r <= reqWrite_r;
                        state_r      <= CSP_HS_XFER;
                    end
                end
                CSP_HS_XFER: begin
                    // One word in flight; simple, costs a cycle per word
                    if (usrTake) begin
                        wrValid_r    <= 1'b1;
                        wrData_r     <= usrWdData;
                        usrWdReady_r <= 1'b0;
                    end else if (wrDone) begin
                        wrValid_r    <= 1'b0;
                        usrWdReady_r <= 1'b1;
                    end
                    if (link.rspValid) begin
                        wrValid_r    <= 1'b0;
                        usrWdReady_r <= 1'b0;
                        doneValid_r  <= 1'b1;
                        doneErr_r    <= link.rspErr;
                        cmdReady_r   <= 1'b1;
                        state_r      <= CSP_HS_IDLE;
                    end
                end
                default: begin
                    state_r <= CSP_HS_IDLE;
                end
            endcase
        end
    end

    assign link.reqValid  = reqValid_r;
    assign link.reqWrite  = reqWrite_r;
    assign link.reqFile   = reqFile_r;
    assign link.reqOffset = reqOffset_r;
    assign link.reqCount  = reqCount_r;
    assign link.wrValid   = wrValid_r;
    assign link.wrData    = wrData_r;
    assign cmdReady       = cmdReady_r;
    assign usrWdReady     = usrWdReady_r;
    assign usrRdValid     = usrRdValid_r;
    assign usrRdData      = usrRdData_r;
    assign doneValid      = doneValid_r;
    assign doneErr        = doneErr_r;

endmodule

// >>> sim/csp_mapper_asserts.sv
`timescale 1ns/1ps
module csp_mapper_asserts (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               reqValid,
    input wire logic               reqReady,
    input wire logic               reqWrite,
    input wire csp_pkg::csp_file_t reqFile,
    input wire csp_pkg::csp_ofs_t  reqOffset,
    input wire csp_pkg::csp_ofs_t  reqCount,
    input wire logic               wrReady,
    input wire logic               rdValid,
    input wire logic               rspValid,
    input wire logic               rspErr
);
    import csp_pkg::*;
    int   startReg;
    logic take, okLin, okBulk, okReq;
    assign take     = reqValid && reqReady;
    assign startReg = (int'(reqFile) - 32'h0A) * 32'h64 + int'(reqOffset);
    assign okLin    = reqFile >= 8'h0A && reqFile <= 8'h3B && reqCount != 13'h0000
                      && reqOffset <= 13'h1364 && startReg >= 32'h1
                      && startReg + int'(reqCount) - 32'h1 <= 32'h1364;
    assign okBulk   = reqFile == 8'h3C && reqCount != 13'h0000 && reqOffset <= 13'h001F
                      && int'(reqOffset) + int'(reqCount) <= 32'h20;
    assign okReq    = okLin || okBulk;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_bad_req_err:
        assert property (take && !okReq |-> ##3 rspValid && rspErr)
        else $error("Bad request not refused");
    a_bulk_ofs_err:
        assert property (take && reqFile == 8'h3C && reqOffset > 13'h001F
                         |-> ##3 rspValid && rspErr)
        else $error("Bulk offset above 31 not refused");
    a_refuse_quiet:
        assert property (take && !okReq |-> (!wrReady && !rdValid)[*3])
        else $error("Refused request moved data");
    a_read_first:
        assert property (take && okLin && !reqWrite |-> !rdValid[*5] ##1 rdValid)
        else $error("First read word late or early");
    a_single_read:
        assert property (take && okReq && !reqWrite && reqCount == 13'h0001
                         |-> ##6 rspValid && !rspErr)
        else $error("Single read response wrong");
    a_wr_accept:
        assert property (take && okReq && reqWrite |-> ##2 wrReady)
        else $error("Write data not accepted");
    a_rd_no_wrrdy:
        assert property (take && !reqWrite |-> !wrReady[*6])
        else $error("Read request took write data");
    a_bulk_rd_first:
        assert property (take && okBulk && !reqWrite |-> ##5 rdValid)
        else $error("Bulk read word missing");
endmodule

// >>> sim/test_csp_register_address_mapper.sv
`timescale 1ns/1ps
module test_csp_register_address_mapper;
    import csp_pkg::*;
    logic       clk = 1'h0, rst_n = 1'h0, connTimeout = 1'h0, sockError = 1'h0;
    logic       cfgWe = 1'h0, cfgConsumed = 1'h0, cmdValid = 1'h0, cmdWrite = 1'h0;
    logic       usrWdValid = 1'h0;
    logic [4:0] cfgIdx = 5'h00;
    csp_reg_t   cfgReg = 13'h0000, regAddr;
    csp_file_t  cmdFile = 8'h00;
    csp_ofs_t   cmdOffset = 13'h0000, cmdCount = 13'h0000;
    csp_word_t  usrWdData = 16'h0000, regWdata, regRdata, usrRdData;
    logic       regRe, regWe, timeoutEvent, cmdReady, usrWdReady, usrRdValid, doneValid, doneErr;
    csp_reg_t   prodMap [32], consMap [32];
    int         errorCnt = 0, nCompared = 0;
    csp_link_if link ();
    always #2.5 clk = ~clk;
    // Register stand-in: the value read back names its register, so misrouting shows
    assign regRdata = {3'h5, regAddr};
    csp_mapper_dev i_csp_mapper_dev (.clk(clk), .rst_n(rst_n), .link(link.dev),
        .connTimeout(connTimeout), .sockError(sockError), .cfgWe(cfgWe),
        .cfgConsumed(cfgConsumed), .cfgIdx(cfgIdx), .cfgReg(cfgReg), .regRe(regRe),
        .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .timeoutEvent(timeoutEvent));
    csp_client_host i_csp_client_host (.clk(clk), .rst_n(rst_n), .link(link.host),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdFile(cmdFile), .cmdOffset(cmdOffset),
        .cmdCount(cmdCount), .cmdReady(cmdReady), .usrWdValid(usrWdValid),
        .usrWdData(usrWdData), .usrWdReady(usrWdReady), .usrRdValid(usrRdValid),
        .usrRdData(usrRdData), .doneValid(doneValid), .doneErr(doneErr));
    csp_mapper_asserts i_csp_mapper_asserts (.clk(clk), .rst_n(rst_n),
        .reqValid(link.reqValid), .reqReady(link.reqReady), .reqWrite(link.reqWrite),
        .reqFile(link.reqFile), .reqOffset(link.reqOffset), .reqCount(link.reqCount),
        .wrReady(link.wrReady), .rdValid(link.rdValid), .rspValid(link.rspValid),
        .rspErr(link.rspErr));

    function automatic csp_word_t wd(input int i);
        return 16'hC000 + 16'(i * 32'h111);
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic giveVerdict();
        $display("Compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic run(input logic w, input csp_file_t f, input csp_ofs_t o,
                       input csp_ofs_t n, input logic e);
        csp_reg_t  gotA [$];
        csp_word_t gotD [$];
        logic      fin, gotErr;
        int        k, i, r;
        fin = 1'h0;
        gotErr = 1'h0;
        i = 0;
        cmdValid <= 1'h1;
        cmdWrite <= w;
        cmdFile <= f;
        cmdOffset <= o;
        cmdCount <= n;
        usrWdValid <= w;
        usrWdData <= wd(0);
        for (k = 0; k < 400 && !fin; k++) begin
            @(posedge clk);
            if (cmdValid && cmdReady) cmdValid <= 1'h0;
            if (usrWdValid && usrWdReady) begin
                i++;
                usrWdValid <= (i < n);
                usrWdData <= wd(i);
            end
            if (regRe || regWe) gotA.push_back(regAddr);
            if (regWe) gotD.push_back(regWdata);
            if (usrRdValid) gotD.push_back(usrRdData);
            if (doneValid) begin
                fin = 1'h1;
                gotErr = doneErr;
            end
        end
        // Withdraw any word still offered; an edge passes so the next call drives it once
        usrWdValid <= 1'h0;
        @(posedge clk);
        chk(fin, 1'h1);
        chk(gotErr, e);
        chk(gotA.size(), e ? 16'h0000 : n);
        for (i = 0; i < gotA.size() && i < n; i++) begin
            r = (f == 8'h3C) ? (w ? consMap[o + i] : prodMap[o + i])
                             : (f - 8'h0A) * 16'h0064 + o + i;
            chk(16'(gotA[i]), 16'(r));
            chk(gotD[i], w ? wd(i) : {3'h5, 13'(r)});
        end
        $display("Test done: write=%0d file %0d offset %0d count %0d", w, f, o, n);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        // Produced map runs downward and consumed map steps by 17, so plain register order cannot pass
        for (int j = 0; j < 32; j++) begin
            prodMap[j] = 13'(16'h1300 - j * 16'h0025);
            consMap[j] = 13'(16'h0100 + j * 16'h0011);
            @(posedge clk);
            cfgWe <= 1'h1;
            cfgConsumed <= 1'h0;
            cfgIdx <= j[4:0];
            cfgReg <= prodMap[j];
            @(posedge clk);
            cfgConsumed <= 1'h1;
            cfgReg <= consMap[j];
        end
        @(posedge clk);
        cfgWe <= 1'h0;
        // Each write carries fresh values and nothing else writes those registers
        run(1'h0, 8'h0A, 13'h0002, 13'h0001, 1'h0);
        run(1'h0, 8'h0C, 13'h003E, 13'h0003, 1'h0);
        run(1'h0, 8'h14, 13'h031E, 13'h0001, 1'h0);
        run(1'h0, 8'h3B, 13'h0040, 13'h0001, 1'h0);
        run(1'h1, 8'h1B, 13'h0063, 13'h0002, 1'h0);
        run(1'h1, 8'h0A, 13'h1364, 13'h0001, 1'h0);
        run(1'h0, 8'h0A, 13'h0000, 13'h0001, 1'h1);
        run(1'h1, 8'h09, 13'h0005, 13'h0001, 1'h1);
        run(1'h0, 8'h3B, 13'h0040, 13'h0002, 1'h1);
        run(1'h1, 8'h0A, 13'h1365, 13'h0001, 1'h1);
        run(1'h0, 8'h3D, 13'h0000, 13'h0001, 1'h1);
        run(1'h0, 8'h14, 13'h0005, 13'h0000, 1'h1);
        run(1'h0, 8'h3C, 13'h0000, 13'h0020, 1'h0);
        run(1'h0, 8'h3C, 13'h001F, 13'h0001, 1'h0);
        run(1'h1, 8'h3C, 13'h000F, 13'h0011, 1'h0);
        run(1'h0, 8'h3C, 13'h000F, 13'h0012, 1'h1);
        run(1'h1, 8'h3C, 13'h0020, 13'h0001, 1'h1);
        for (int j = 1; j < 4; j++) begin
            @(posedge clk);
            connTimeout <= j[0];
            sockError <= j[1];
            @(posedge clk);
            connTimeout <= 1'h0;
            sockError <= 1'h0;
            @(posedge clk);
            chk(timeoutEvent, 1'h1);
            @(posedge clk);
            chk(timeoutEvent, 1'h0);
        end
        $display("Test done: timeout event");
        giveVerdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        giveVerdict();
    end
endmodule
